// ### hw/spm_consts.svh
// offsets, field positions and sizes of the serial port status bank
// assumes a 12-bit byte address on the apb port
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
`define OFF_STATUS 12'h000
`define OFF_LINK 12'h004
`define OFF_CTRL 12'h008
`define OFF_ERR_KIND 12'h00c
`define OFF_SET_CHG 12'h010
`define OFF_UNIT_LO 12'h014
`define OFF_UNIT_HI 12'h018
`define OFF_MASTER 12'h01c
`define OFF_RX_DATA 12'h020
`define OFF_DM_BASE 12'h400
`define DM_WORDS 200
`define DM_IDX_W 8
`define DM_ERR_PORT1 8'h98
`define DM_ERR_PORT2 8'h34
`define BIT_COMM_ERR 4
`define BIT_SEND_RDY 5
`define BIT_RX_DONE 6
`define BIT_RX_OVF 7
`define BIT_RESTART 0
`define BIT_SET_CHG 2
`define MB_EXEC 0
`define MB_NORMAL 1
`define MB_ERROR 2
`define MB_PORT1_SHIFT 8
`define MODE_CODE_TERM 2'h1
`define MODE_CODE_MODBUS 2'h2
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8
`endif

// ### hw/spm_pkg.sv
// types shared by the serial port status bank and its surroundings
// assumes the constants header is included by users that need offsets
package spm_pkg;
  // one-hot port operating mode
  typedef enum logic [2:0] {
    mode_raw = 3'b001,
    mode_terminal = 3'b010,
    mode_modbus = 3'b100
  } port_mode_t;
  // one-hot restart sequencer
  typedef enum logic [1:0] {
    rs_idle = 2'b01,
    rs_busy = 2'b10
  } restart_state_t;
  // result of one master exchange, from the line engine
  typedef struct packed {
    logic done;
    logic ok;
    logic [15:0] code;
  } mb_result_t;
  // one received byte from the line engine
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_t;
endpackage

// ### hw/serial_port_status_modbus_master.sv
// status/control bank of serial port two, unit settings flags and
// the two-port simple master handshake, reached over apb
// assumes a line engine beside it doing framing and timing
//
// Behaviour
// R1 - any port-two line error sets error flag
// R2 - restart request reinitialises serial port two
// R3 - settings-changing flag high during settings change
// R4 - eight error-kind flags report error type
// R5 - raw mode send-ready while port accepts data
// R6 - raw mode reception-complete flag after reception
// R7 - raw mode overflow flag on receive overflow
// R8 - terminal mode: per-terminal communicating flags
// R9 - terminal mode: priority terminal flag group
// R10 - raw mode sixteen-bit received byte count
// R11 - settings-changing flag per unit port
// R12 - execute bit sends one command, stays high
// R13 - execute bit self-clears after exchange completes
// R14 - normal flag set after successful exchange
// R15 - normal flag low while running or failed
// R16 - error sets flag and stores error code
// R17 - error flag low while normal or running
// R18 - each port owns its data_memory_area block
`timescale 1ns/1ps
`include "spm_consts.svh"

module fifo_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage has no reset; only the pointers and the count carry state
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap at depth; depth is a power of two here
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module serial_port_status_modbus_master (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // port two line engine
  input wire logic line_error_i,
  input wire logic [7:0] error_kind_i,
  input wire logic tx_ready_i,
  input wire logic rx_start_i,
  input wire logic rx_end_i,
  input wire spm_pkg::rx_byte_t rx_byte_i,
  output logic rx_ready_o,
  input wire logic [7:0] terminal_active_i,
  input wire logic [7:0] terminal_priority_i,
  output spm_pkg::port_mode_t port_mode_o,
  output logic restart_o,
  input wire logic restart_done_i,
  output logic settings_change_o,
  input wire logic settings_done_i,
  // communications unit ports, bit = unit*4 + port-1
  input wire logic [63:0] unit_change_start_i,
  input wire logic [63:0] unit_change_done_i,
  // master engines, index 0 = port one, 1 = port two
  output logic [1:0] mb_start_o,
  input wire spm_pkg::mb_result_t [1:0] mb_result_i
);
  import spm_pkg::*;

  port_mode_t mode;
  restart_state_t rs_state;
  logic comm_err;
  logic send_rdy;
  logic rx_done;
  logic rx_ovf;
  logic [15:0] rx_count;
  logic [7:0] term_act;
  logic [7:0] term_prio;
  logic [7:0] err_kind;
  logic set_chg;
  logic [63:0] unit_chg;
  logic [1:0] exec;
  logic [1:0] normal;
  logic [1:0] mb_err;
  logic [15:0] dm [`DM_WORDS];
  logic setup;
  logic wr;
  logic rd_pop;
  logic raw;
  logic restart_req;
  logic [1:0] start_req;
  logic [11:0] dm_off;
  logic [`DM_IDX_W-1:0] dm_idx;
  logic dm_hit;
  logic [31:0] next_rdata;
  logic next_err;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic rx_take;

  // decode; writes land on the access edge, reads are captured at setup
  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd_pop = psel_i && penable_i && !pwrite_i
    && (paddr_i == `OFF_RX_DATA);
  assign pready_o = 1'b1;
  assign raw = (mode == mode_raw);
  assign restart_req = wr && (paddr_i == `OFF_CTRL)
    && pwdata_i[`BIT_RESTART];
  assign dm_off = paddr_i - `OFF_DM_BASE;
  assign dm_idx = dm_off[`DM_IDX_W+1:2];
  assign dm_hit = (paddr_i >= `OFF_DM_BASE)
    && (dm_off[11:2] < 10'(`DM_WORDS));
  assign start_req[0] = wr && (paddr_i == `OFF_MASTER)
    && pwdata_i[`MB_PORT1_SHIFT + `MB_EXEC];
  assign start_req[1] = wr && (paddr_i == `OFF_MASTER)
    && pwdata_i[`MB_EXEC];
  assign port_mode_o = mode;
  assign restart_o = (rs_state == rs_busy);
  assign settings_change_o = set_chg;
  assign rx_take = rx_byte_i.valid && rx_ready_o;

  // receive buffer; a full buffer stalls the line engine
  fifo_buf #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .flush_i(restart_o),
    .in_valid_i(rx_byte_i.valid && raw),
    .in_data_i(rx_byte_i.data),
    .in_ready_o(rx_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(rd_pop)
  );

  // read mux; link word is shared by the count and the terminal flags
  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    case (paddr_i)
      `OFF_STATUS: begin
        next_rdata[`BIT_COMM_ERR] = comm_err;
        next_rdata[`BIT_SEND_RDY] = send_rdy;
        next_rdata[`BIT_RX_DONE] = rx_done;
        next_rdata[`BIT_RX_OVF] = rx_ovf;
      end
      `OFF_LINK: begin
        next_rdata[15:0] = raw ? rx_count : {term_prio, term_act}; // R10
      end
      `OFF_CTRL: begin
        next_rdata[`BIT_RESTART] = restart_o;
        next_rdata[2:1] = (mode == mode_terminal) ? `MODE_CODE_TERM
          : (mode == mode_modbus) ? `MODE_CODE_MODBUS : 2'h0;
      end
      `OFF_ERR_KIND: next_rdata[7:0] = err_kind;
      `OFF_SET_CHG: next_rdata[`BIT_SET_CHG] = set_chg;
      `OFF_UNIT_LO: next_rdata = unit_chg[31:0];
      `OFF_UNIT_HI: next_rdata = unit_chg[63:32];
      `OFF_MASTER: begin
        next_rdata[2:0] = {mb_err[1], normal[1], exec[1]};
        next_rdata[10:8] = {mb_err[0], normal[0], exec[0]};
      end
      `OFF_RX_DATA: next_rdata[8:0] = {fifo_valid, fifo_data};
      default: begin
        if (dm_hit) begin
          next_rdata[15:0] = dm[dm_idx];
        end else begin
          next_err = 1'b1;
        end
      end
    endcase
  end

  // answer registered at setup so the access phase sees flip-flops
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? 32'h0 : next_rdata;
      pslverr_o <= next_err;
    end
  end

  // mode field and restart sequencer
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode <= mode_raw;
      rs_state <= rs_idle;
    end else begin
      if (wr && paddr_i == `OFF_CTRL) begin
        case (pwdata_i[2:1])
          `MODE_CODE_TERM: mode <= mode_terminal;
          `MODE_CODE_MODBUS: mode <= mode_modbus;
          default: mode <= mode_raw;
        endcase
      end
      case (rs_state)
        rs_idle: if (restart_req) rs_state <= rs_busy; // R2
        rs_busy: if (restart_done_i) rs_state <= rs_idle;
        default: rs_state <= rs_idle;
      endcase
    end
  end

  // error flags; an event in the restart cycle still sets the flag
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comm_err <= 1'b0;
      err_kind <= 8'h0;
    end else begin
      if (line_error_i) begin
        comm_err <= 1'b1; // R1
      end else if (restart_o) begin
        comm_err <= 1'b0;
      end
      if (wr && paddr_i == `OFF_ERR_KIND) begin
        err_kind <= pwdata_i[7:0] | error_kind_i; // R4
      end else if (restart_o) begin
        err_kind <= error_kind_i;
      end else begin
        err_kind <= err_kind | error_kind_i; // R4
      end
    end
  end

  // raw-mode receive status and byte count
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      send_rdy <= 1'b0;
      rx_done <= 1'b0;
      rx_ovf <= 1'b0;
      rx_count <= 16'h0;
    end else begin
      send_rdy <= raw && tx_ready_i && !restart_o; // R5
      if (raw && rx_end_i) begin
        rx_done <= 1'b1; // R6
      end else if (restart_o || rx_start_i || !raw) begin
        rx_done <= 1'b0;
      end
      // a byte offered while the buffer is full counts as overflow
      if (raw && rx_byte_i.valid && !rx_ready_o) begin
        rx_ovf <= 1'b1; // R7
      end else if (restart_o || rx_start_i || !raw) begin
        rx_ovf <= 1'b0;
      end
      if (restart_o || rx_start_i || !raw) begin
        rx_count <= 16'h0;
      end else if (rx_take) begin
        rx_count <= rx_count + 16'h0001; // R10
      end
    end
  end

  // terminal flags follow the engine only in terminal mode
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      term_act <= 8'h0;
      term_prio <= 8'h0;
    end else if (mode == mode_terminal) begin
      term_act <= terminal_active_i; // R8
      term_prio <= terminal_priority_i; // R9
    end else begin
      term_act <= 8'h0;
      term_prio <= 8'h0;
    end
  end

  // settings-changing flags: software or unit starts, engine or unit ends
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      set_chg <= 1'b0;
      unit_chg <= 64'h0;
    end else begin
      if (wr && paddr_i == `OFF_SET_CHG && pwdata_i[`BIT_SET_CHG]) begin
        set_chg <= 1'b1; // R3
      end else if (settings_done_i) begin
        set_chg <= 1'b0;
      end
      if (wr && paddr_i == `OFF_UNIT_LO) begin
        unit_chg[31:0] <= pwdata_i | unit_change_start_i[31:0];
      end else begin
        unit_chg[31:0] <= (unit_chg[31:0] & ~unit_change_done_i[31:0])
          | unit_change_start_i[31:0]; // R11
      end
      if (wr && paddr_i == `OFF_UNIT_HI) begin
        unit_chg[63:32] <= pwdata_i | unit_change_start_i[63:32];
      end else begin
        unit_chg[63:32] <= (unit_chg[63:32] & ~unit_change_done_i[63:32])
          | unit_change_start_i[63:32]; // R11
      end
    end
  end

  // master handshake per port; a start while busy is ignored
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      exec <= 2'b00;
      normal <= 2'b00;
      mb_err <= 2'b00;
      mb_start_o <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        mb_start_o[p] <= 1'b0;
        if (start_req[p] && !exec[p]) begin
          exec[p] <= 1'b1; // R12
          normal[p] <= 1'b0; // R15
          mb_err[p] <= 1'b0; // R17
          mb_start_o[p] <= 1'b1; // R12
        end else if (exec[p] && mb_result_i[p].done) begin
          exec[p] <= 1'b0; // R13
          normal[p] <= mb_result_i[p].ok; // R14
          mb_err[p] <= !mb_result_i[p].ok; // R16
        end
      end
    end
  end

  // data_memory_area: word 0 is the first word of the port two block;
  // a failing exchange overrides a software write in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (wr && dm_hit) begin
      dm[dm_idx] <= pwdata_i[15:0]; // R18
    end
    // both ports may fail in one cycle; neither code may be lost
    if (exec[0] && mb_result_i[0].done && !mb_result_i[0].ok) begin
      dm[`DM_ERR_PORT1] <= mb_result_i[0].code; // R16
    end
    if (exec[1] && mb_result_i[1].done && !mb_result_i[1].ok) begin
      dm[`DM_ERR_PORT2] <= mb_result_i[1].code; // R16
    end
  end

  // checks
  property p_comm_err;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    line_error_i |=> comm_err;
  endproperty
  a_comm_err: assert property (p_comm_err) // R1
    else $error("line error did not set error flag");

  property p_restart;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (restart_req && !restart_o) |=> restart_o throughout
      (!restart_done_i [*1] or restart_done_i [*1]);
  endproperty
  a_restart: assert property (p_restart) // R2
    else $error("restart request not acted on");

  property p_set_chg;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (set_chg && !settings_done_i) |=> set_chg;
  endproperty
  a_set_chg: assert property (p_set_chg) // R3
    else $error("settings flag dropped during change");

  property p_overflow;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (raw && rx_byte_i.valid && !rx_ready_o) |=> rx_ovf;
  endproperty
  a_overflow: assert property (p_overflow) // R7
    else $error("overflow not flagged");

  property p_count;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (raw && rx_take && !restart_o && !rx_start_i)
      |=> rx_count == $past(rx_count) + 16'h0001;
  endproperty
  a_count: assert property (p_count) // R10
    else $error("byte count did not advance by one");

  property p_start;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (start_req[1] && !exec[1]) |=> mb_start_o[1] && exec[1]
      ##1 !mb_start_o[1];
  endproperty
  a_start: assert property (p_start) // R12
    else $error("execute did not launch one command");

  property p_done_ok;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (exec[0] && mb_result_i[0].done && mb_result_i[0].ok)
      |=> !exec[0] && normal[0] && !mb_err[0];
  endproperty
  a_done_ok: assert property (p_done_ok) // R14
    else $error("good exchange not reported normal");

  property p_busy_flags;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    exec != 2'b00 |-> (normal & exec) == 2'b00 && (mb_err & exec) == 2'b00;
  endproperty
  a_busy_flags: assert property (p_busy_flags) // R15
    else $error("result flag high while executing");

  property p_done_err;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (exec[1] && mb_result_i[1].done && !mb_result_i[1].ok)
      |=> !exec[1] && mb_err[1] && !normal[1]
      && dm[`DM_ERR_PORT2] == $past(mb_result_i[1].code);
  endproperty
  a_done_err: assert property (p_done_err) // R16
    else $error("failed exchange not reported");

  c_ok: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    exec[0] ##[1:20] normal[0]);
  c_err: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    exec[1] ##[1:20] mb_err[1]);
  c_full: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    raw && !rx_ready_o);
  c_restart: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    restart_o ##1 !restart_o);
endmodule

// ### bench/line_engine_model.sv
// stand-in for the port line engine: answers restart, settings
// change and master exchanges after DELAY cycles
// assumes level requests for restart/settings, one-cycle starts
`timescale 1ns/1ps
module line_engine_model #(
  parameter int DELAY = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // requests from the bank
  input wire logic restart_i,
  input wire logic settings_i,
  input wire logic [1:0] start_i,
  // outcome chosen by the bench
  input wire logic [1:0] ok_i,
  input wire logic [15:0] code_i,
  // answers
  output logic restart_done_o,
  output logic settings_done_o,
  output spm_pkg::mb_result_t [1:0] result_o
);
  import spm_pkg::*;
  int rs_cnt;
  int sc_cnt;
  int mb_cnt [2];

  // restart and settings end with one pulse while still requested
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rs_cnt <= 0;
      sc_cnt <= 0;
      restart_done_o <= 1'b0;
      settings_done_o <= 1'b0;
    end else begin
      restart_done_o <= restart_i && rs_cnt == DELAY - 1;
      rs_cnt <= (restart_i && rs_cnt < DELAY) ? rs_cnt + 1 : 0;
      settings_done_o <= settings_i && sc_cnt == DELAY - 1;
      sc_cnt <= (settings_i && sc_cnt < DELAY) ? sc_cnt + 1 : 0;
    end
  end

  // one exchange per start; outside done the result lines churn
  // so a bank that looks at them early sees garbage, not old data
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mb_cnt <= '{0, 0};
      result_o <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (start_i[p]) begin
          mb_cnt[p] <= DELAY;
        end else if (mb_cnt[p] != 0) begin
          mb_cnt[p] <= mb_cnt[p] - 1;
        end
        result_o[p].done <= mb_cnt[p] == 1;
        result_o[p].ok <= (mb_cnt[p] == 1) ? ok_i[p] : ~result_o[p].ok;
        result_o[p].code <= (mb_cnt[p] == 1) ? code_i :
                            ~result_o[p].code;
      end
    end
  end
endmodule

// ### bench/tb_top.sv
// self-checking bench of the serial port status bank over apb
// assumes the line engine stand-in answers in eight cycles
`timescale 1ns/1ps
`include "spm_consts.svh"
module tb_top;
  import spm_pkg::*;
  logic ref_clk_i, resetn_i, psel, penable, pwrite, pready, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp_m;
  logic line_error, tx_ready, rx_start, rx_end, rx_ready, restart;
  logic rs_done, sc, sc_done, pslverr;
  logic [7:0] err_kind, t_act, t_pri;
  rx_byte_t rx_byte;
  port_mode_t mode;
  logic [63:0] u_start, u_done;
  logic [1:0] mb_start, mb_ok;
  logic [15:0] mb_code;
  logic [3:0] res [2];
  mb_result_t [1:0] mb_res;
  int errors, tests_run, p, sh;

  serial_port_status_modbus_master u_serial_port_status_modbus_master (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .line_error_i(line_error),
    .error_kind_i(err_kind), .tx_ready_i(tx_ready),
    .rx_start_i(rx_start), .rx_end_i(rx_end), .rx_byte_i(rx_byte),
    .rx_ready_o(rx_ready), .terminal_active_i(t_act),
    .terminal_priority_i(t_pri), .port_mode_o(mode),
    .restart_o(restart), .restart_done_i(rs_done),
    .settings_change_o(sc), .settings_done_i(sc_done),
    .unit_change_start_i(u_start), .unit_change_done_i(u_done),
    .mb_start_o(mb_start), .mb_result_i(mb_res));

  line_engine_model #(.DELAY(8)) u_line_engine_model (
    .clk_i(ref_clk_i), .resetn_i(resetn_i), .restart_i(restart),
    .settings_i(sc), .start_i(mb_start), .ok_i(mb_ok),
    .code_i(mb_code), .restart_done_o(rs_done),
    .settings_done_o(sc_done), .result_o(mb_res));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  // one apb transfer; holds everything until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      give_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input string what, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask

  // reread a word until the masked bits drop, bounded
  task poll(input logic [11:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== 32'h0 && n < 30);
    if ((rd & m) !== 32'h0) begin
      errors++;
      give_verdict;
    end
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {line_error, tx_ready, rx_start, rx_end, err_kind} = '0;
    {t_act, t_pri, u_start, u_done, mb_ok, mb_code} = '0;
    rx_byte = '{1'b0, 8'h5a};
    errors = 0;
    tests_run = 0;
    resetn_i = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rchk("status", `OFF_STATUS, 32'h0);
    rchk("master", `OFF_MASTER, 32'h0);
    chk("rx_ready", 32'h1, {31'h0, rx_ready});
    apb(1'b1, `OFF_STATUS, 32'hff);
    rchk("status_ro", `OFF_STATUS, 32'h0);
    chk("mapped", 32'h0, {31'h0, err});
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test reset done");
    // raw stream: nine bytes at a full-speed source, eight fit
    @(posedge ref_clk_i);
    tx_ready <= 1'b1;
    rx_start <= 1'b1;
    @(posedge ref_clk_i);
    rx_start <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk_i);
      rx_byte <= '{1'b1, 8'h10 + i[7:0]};
    end
    @(posedge ref_clk_i);
    rx_byte <= '{1'b0, 8'ha5};
    rx_end <= 1'b1;
    @(posedge ref_clk_i);
    rx_end <= 1'b0;
    chk("rx_ready_full", 32'h0, {31'h0, rx_ready});
    rchk("status_raw", `OFF_STATUS, 32'he0);
    rchk("rx_count", `OFF_LINK, 32'h8);
    for (int i = 0; i < 8; i++) begin
      rchk("rx_data", `OFF_RX_DATA, 32'h110 + i);
    end
    apb(1'b0, `OFF_RX_DATA, 32'h0);
    chk("rx_empty", 32'h0, {31'h0, rd[8]});
    @(posedge ref_clk_i);
    tx_ready <= 1'b0;
    rchk("send_ready_off", `OFF_STATUS, 32'hc0);
    $display("test raw stream done");
    // line error, error kinds, then restart clears them
    @(posedge ref_clk_i);
    line_error <= 1'b1;
    err_kind <= 8'h05;
    @(posedge ref_clk_i);
    line_error <= 1'b0;
    err_kind <= 8'h00;
    rchk("comm_err", `OFF_STATUS, 32'hd0);
    rchk("err_kind", `OFF_ERR_KIND, 32'h05);
    apb(1'b1, `OFF_ERR_KIND, 32'h80);
    rchk("err_kind_wr", `OFF_ERR_KIND, 32'h80);
    apb(1'b1, `OFF_CTRL, 32'h1);
    #1;
    chk("restart_on", 32'h1, {31'h0, restart});
    poll(`OFF_CTRL, 32'h1);
    chk("restart_off", 32'h0, {31'h0, restart});
    rchk("status_restart", `OFF_STATUS, 32'h0);
    rchk("kind_restart", `OFF_ERR_KIND, 32'h0);
    $display("test restart done");
    // terminal link flags
    apb(1'b1, `OFF_CTRL, {29'h0, `MODE_CODE_TERM, 1'b0});
    t_act <= 8'h81;
    t_pri <= 8'h04;
    #1;
    chk("mode_term", {29'h0, mode_terminal}, {29'h0, mode});
    rchk("link", `OFF_LINK, 32'h0481);
    $display("test terminal done");
    // settings change held until the engine finishes
    apb(1'b1, `OFF_SET_CHG, 32'h4);
    #1;
    chk("set_chg_pin", 32'h1, {31'h0, sc});
    rchk("set_chg", `OFF_SET_CHG, 32'h4);
    poll(`OFF_SET_CHG, 32'h4);
    chk("set_chg_end", 32'h0, {31'h0, sc});
    // unit port flags at both ends of the 64
    @(posedge ref_clk_i);
    u_start <= {1'b1, 62'h0, 1'b1};
    @(posedge ref_clk_i);
    u_start <= '0;
    rchk("unit_lo", `OFF_UNIT_LO, 32'h1);
    rchk("unit_hi", `OFF_UNIT_HI, 32'h80000000);
    @(posedge ref_clk_i);
    u_done <= 64'h1;
    @(posedge ref_clk_i);
    u_done <= '0;
    rchk("unit_done", `OFF_UNIT_LO, 32'h0);
    $display("test settings done");
    // master exchanges: both ports, success then failure
    apb(1'b1, `OFF_CTRL, {29'h0, `MODE_CODE_MODBUS, 1'b0});
    rchk("link_modbus", `OFF_LINK, 32'h0);
    res = '{4'h0, 4'h0};
    for (int k = 0; k < 4; k++) begin
      p = k % 2;
      sh = (p == 0) ? 8 : 0;
      mb_ok[p] <= (k < 2);
      mb_code <= 16'h0a00 + k[15:0];
      apb(1'b1, `OFF_MASTER, 32'h1 << sh);
      #1;
      chk("mb_start", 32'h1, {31'h0, mb_start[p]});
      res[p] = 4'h1;
      exp_m = {res[0], 8'h0} | res[1];
      rchk("exec_run", `OFF_MASTER, exp_m);
      poll(`OFF_MASTER, 32'h1 << sh);
      res[p] = (k < 2) ? 4'h2 : 4'h4;
      exp_m = {res[0], 8'h0} | res[1];
      rchk("exec_end", `OFF_MASTER, exp_m);
      if (k >= 2) begin
        rchk("err_code", `OFF_DM_BASE + ((p == 0) ? 12'h260 : 12'h0d0),
             {16'h0, 16'h0a00 + k[15:0]});
      end
    end
    $display("test master done");
    give_verdict;
  end
endmodule
